// >>> common/lsx_pkg.sv
// Package of opcodes, register offsets, field layouts and reset values for the load/store unit
package lsx_pkg;

  // Instruction fields: mode in bits 0-2, operation in 3-7, displacement in 8-15 (bit 0 = msb)
  localparam int MODE_MSB = 15;
  localparam int MODE_LSB = 13;
  localparam int OP_MSB   = 12;
  localparam int OP_LSB   = 8;
  localparam int DISP_MSB = 7;
  localparam int DISP_LSB = 0;

  // Operation field codes
  localparam logic [4:0] OP_LOAD_ACC    = 5'h00;
  localparam logic [4:0] OP_LOAD_EXT    = 5'h01;
  localparam logic [4:0] OP_LOAD_IDX    = 5'h02;
  localparam logic [4:0] OP_EFF_ADDR    = 5'h04;
  localparam logic [4:0] OP_BYTE_IDX    = 5'h0f;
  localparam logic [4:0] OP_STORE_ACC   = 5'h11;
  localparam logic [4:0] OP_STORE_EXT   = 5'h12;
  localparam logic [4:0] OP_STORE_IDX   = 5'h13;
  localparam logic [4:0] OP_STORE_RBYTE = 5'h15;
  localparam logic [4:0] OP_SAVE_RET    = 5'h18;
  localparam logic [4:0] OP_LOAD_RF     = 5'h19;
  localparam logic [4:0] OP_STORE_RF    = 5'h1a;

  // Return address increment
  localparam logic [15:0] RET_INCR = 16'h0004;

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_INSTR  = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_PADDR  = 8'h0c;
  localparam logic [7:0] REG_GBASE  = 8'h10;
  localparam logic [7:0] REG_ACC    = 8'h14;
  localparam logic [7:0] REG_EXT    = 8'h18;
  localparam logic [7:0] REG_IDX    = 8'h1c;
  localparam logic [7:0] REG_FLAGS  = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;
  localparam logic [7:0] REG_MASK   = 8'h28;
  localparam logic [7:0] REG_RFSEL  = 8'h2c;
  localparam logic [7:0] REG_RFDATA = 8'h30;

  // Control bits
  localparam int CTRL_GO     = 0;
  localparam int CTRL_MASTER = 1;

  // Status bits: done, mode violation, unknown op
  localparam int ST_DONE = 0;
  localparam int ST_MVIO = 1;
  localparam int ST_ILL  = 2;
  localparam int ST_W    = 3;

  // Reset values
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [ST_W-1:0] RST_MASK = 3'h0;
  localparam int RF_DEPTH = 8;

  // Flag encodings (positive, negative, zero)
  localparam logic [1:0] FL_POS  = 2'b00;
  localparam logic [1:0] FL_NEG  = 2'b01;
  localparam logic [1:0] FL_ZERO = 2'b10;

endpackage

// >>> rtl/lsx_flag_gen.sv
`timescale 1ns/1ps
// Positive/negative/zero flag encoder from a loaded word's sign and zero state
module lsx_flag_gen
  import lsx_pkg::*;
(
  // Value in
  input  wire logic [15:0] value,
  // Flags out
  output logic      [1:0]  flags
);
  // Zero wins over sign; bit 15 is the sign
  always_comb begin
    if (value == RST_WORD) begin
      flags = FL_ZERO;
    end else if (value[15]) begin
      flags = FL_NEG;
    end else begin
      flags = FL_POS;
    end
  end
endmodule

// >>> rtl/lsx_load_store_unit.sv
`timescale 1ns/1ps
// Load/store execution unit with APB registers and a core memory port
// Contract
// - Store-right-byte writes accumulator low byte to addressed byte, nothing else changes.
// - Load-byte-into-index puts memory byte into index low byte.
// - It clears index high byte; flags 10 if index zero, else 00.
// - Load-accumulator copies word; flags 00 positive, 01 negative, 10 zero.
// - Store-accumulator writes whole accumulator; registers and flags unchanged.
// - Load-extension copies word into extension with accumulator-style flags.
// - Store-extension writes extension register to memory word; nothing else changes.
// - Load-index copies word into index with accumulator-style flags.
// - Store-index writes index register to memory word; nothing else changes.
// - Load-from-regfile copies register numbered by operand into accumulator, sets flags.
// - Store-to-regfile writes accumulator into register numbered by operand.
// - Store-to-regfile only in master mode; slave mode raises mode violation.
// - Effective-address puts computed address minus general base into accumulator.
// - Save-return-address stores instruction address plus 4 plus mode base to memory.
// - Word address: even byte address kept, odd address minus one.
// - Mode base is general base in master mode, zero in slave.
module lsx_load_store_unit
  import lsx_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core memory port, byte addressed
  output logic             memReq,
  output logic             memWrite,
  output logic             memByte,
  output logic      [15:0] memAddr,
  output logic      [15:0] memWdata,
  input  wire logic [15:0] memRdata,
  input  wire logic        memAck,
  // Interrupt
  output logic             irq
);

  typedef enum logic [1:0] {S_IDLE, S_MEM, S_DONE} lsx_state_t;

  typedef struct packed {
    lsx_state_t             state;
    logic                   master;
    logic [15:0]            instr;
    logic [15:0]            addr;
    logic [15:0]            pAddr;
    logic [15:0]            gBase;
    logic [15:0]            acc;
    logic [15:0]            ext;
    logic [15:0]            idx;
    logic [1:0]             flags;
    logic [ST_W-1:0]        status;
    logic [ST_W-1:0]        mask;
    logic [2:0]             rfSel;
    logic [RF_DEPTH-1:0][15:0] rf;
    logic                   busy;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   memReq;
    logic                   memWrite;
    logic                   memByte;
    logic [15:0]            memAddr;
    logic [15:0]            memWdata;
    logic                   irq;
  } lsx_regs_t;

  lsx_regs_t cur_ff;
  lsx_regs_t nxt_cur;

  logic [1:0]  memFlags;
  logic [1:0]  rfFlags;
  logic [15:0] rfWord;
  logic [4:0]  opCode;
  logic        busWr;
  logic        busRd;

  // Word address of a byte address
  function automatic logic [15:0] wordAddr(input logic [15:0] a);
    wordAddr = {a[15:1], 1'b0};
  endfunction

  // Base adjustment by mode
  function automatic logic [15:0] modeBase(input logic m, input logic [15:0] g);
    modeBase = m ? g : RST_WORD;
  endfunction

  // Field split; addressing mode is resolved upstream into the computed address
  assign opCode = cur_ff.instr[OP_MSB:OP_LSB];
  assign rfWord = cur_ff.rf[cur_ff.addr[2:0]];
  assign busWr  = psel & penable & pwrite & ~cur_ff.pready;
  assign busRd  = psel & penable & ~pwrite & ~cur_ff.pready;

  // Flags for loaded words and register-file reads
  lsx_flag_gen uMemFlags (
    .value (memRdata),
    .flags (memFlags)
  );
  lsx_flag_gen uRfFlags (
    .value (rfWord),
    .flags (rfFlags)
  );

  // Whole next-state computation
  always_comb begin
    logic [ST_W-1:0] evt;
    evt = '0;
    nxt_cur = cur_ff;
    nxt_cur.pready  = 1'b0;
    nxt_cur.pslverr = 1'b0;

    // Instruction sequencing
    unique case (cur_ff.state)
      S_IDLE: begin
        if (cur_ff.busy) begin
          nxt_cur.state = S_DONE;
          nxt_cur.memAddr = wordAddr(cur_ff.addr);
          nxt_cur.memByte = 1'b0;
          nxt_cur.memWrite = 1'b0;
          case (opCode)
            OP_LOAD_ACC, OP_LOAD_EXT, OP_LOAD_IDX: begin
              nxt_cur.memReq = 1'b1;
              nxt_cur.state = S_MEM;
            end
            OP_BYTE_IDX: begin
              nxt_cur.memReq = 1'b1;
              nxt_cur.memByte = 1'b1;
              nxt_cur.memAddr = cur_ff.addr;
              nxt_cur.state = S_MEM;
            end
            OP_STORE_RBYTE: begin
              nxt_cur.memReq = 1'b1;
              nxt_cur.memWrite = 1'b1;
              nxt_cur.memByte = 1'b1;
              nxt_cur.memAddr = cur_ff.addr;
              nxt_cur.memWdata = {8'h00, cur_ff.acc[7:0]};
              nxt_cur.state = S_MEM;
            end
            OP_STORE_ACC, OP_STORE_EXT, OP_STORE_IDX, OP_SAVE_RET: begin
              nxt_cur.memReq = 1'b1;
              nxt_cur.memWrite = 1'b1;
              nxt_cur.state = S_MEM;
              if (opCode == OP_STORE_ACC) begin
                nxt_cur.memWdata = cur_ff.acc;
              end else if (opCode == OP_STORE_EXT) begin
                nxt_cur.memWdata = cur_ff.ext;
              end else if (opCode == OP_STORE_IDX) begin
                nxt_cur.memWdata = cur_ff.idx;
              end else begin
                nxt_cur.memWdata = cur_ff.pAddr + RET_INCR + modeBase(cur_ff.master, cur_ff.gBase);
              end
            end
            OP_LOAD_RF: begin
              nxt_cur.acc = rfWord;
              nxt_cur.flags = rfFlags;
            end
            OP_STORE_RF: begin
              if (cur_ff.master) begin
                nxt_cur.rf[cur_ff.addr[2:0]] = cur_ff.acc;
              end else begin
                evt[ST_MVIO] = 1'b1;
              end
            end
            OP_EFF_ADDR: begin
              nxt_cur.acc = cur_ff.addr - cur_ff.gBase;
            end
            default: begin
              evt[ST_ILL] = 1'b1;
            end
          endcase
        end
      end
      S_MEM: begin
        if (memAck) begin
          nxt_cur.memReq = 1'b0;
          nxt_cur.memWrite = 1'b0;
          nxt_cur.state = S_DONE;
          // Stores leave every register and flag alone
          if (!cur_ff.memWrite) begin
            case (opCode)
              OP_LOAD_ACC: begin
                nxt_cur.acc = memRdata;
                nxt_cur.flags = memFlags;
              end
              OP_LOAD_EXT: begin
                nxt_cur.ext = memRdata;
                nxt_cur.flags = memFlags;
              end
              OP_LOAD_IDX: begin
                nxt_cur.idx = memRdata;
                nxt_cur.flags = memFlags;
              end
              default: begin
                nxt_cur.idx = {8'h00, memRdata[7:0]};
                nxt_cur.flags = (memRdata[7:0] == 8'h00) ? FL_ZERO : FL_POS;
              end
            endcase
          end
        end
      end
      S_DONE: begin
        nxt_cur.busy = 1'b0;
        nxt_cur.state = S_IDLE;
        evt[ST_DONE] = 1'b1;
      end
      default: begin
        nxt_cur.state = S_IDLE;
      end
    endcase

    // APB access, one wait state; register writes take effect even while busy, only go is ignored
    if (psel & penable & ~cur_ff.pready) begin
      nxt_cur.pready = 1'b1;
    end
    if (busRd) begin
      unique case (paddr)
        REG_CTRL:   nxt_cur.prdata = {30'h0, cur_ff.master, cur_ff.busy};
        REG_INSTR:  nxt_cur.prdata = {16'h0, cur_ff.instr};
        REG_ADDR:   nxt_cur.prdata = {16'h0, cur_ff.addr};
        REG_PADDR:  nxt_cur.prdata = {16'h0, cur_ff.pAddr};
        REG_GBASE:  nxt_cur.prdata = {16'h0, cur_ff.gBase};
        REG_ACC:    nxt_cur.prdata = {16'h0, cur_ff.acc};
        REG_EXT:    nxt_cur.prdata = {16'h0, cur_ff.ext};
        REG_IDX:    nxt_cur.prdata = {16'h0, cur_ff.idx};
        REG_FLAGS:  nxt_cur.prdata = {30'h0, cur_ff.flags};
        REG_STATUS: nxt_cur.prdata = {29'h0, cur_ff.status};
        REG_MASK:   nxt_cur.prdata = {29'h0, cur_ff.mask};
        REG_RFSEL:  nxt_cur.prdata = {29'h0, cur_ff.rfSel};
        REG_RFDATA: nxt_cur.prdata = {16'h0, cur_ff.rf[cur_ff.rfSel]};
        default: begin
          nxt_cur.prdata = 32'h0;
          nxt_cur.pslverr = 1'b1;
        end
      endcase
    end else if (busWr) begin
      nxt_cur.prdata = 32'h0;
      unique case (paddr)
        REG_CTRL: begin
          nxt_cur.master = pwdata[CTRL_MASTER];
          if (pwdata[CTRL_GO] && !cur_ff.busy) begin
            nxt_cur.busy = 1'b1;
          end
        end
        REG_INSTR:  nxt_cur.instr = pwdata[15:0];
        REG_ADDR:   nxt_cur.addr = pwdata[15:0];
        REG_PADDR:  nxt_cur.pAddr = pwdata[15:0];
        REG_GBASE:  nxt_cur.gBase = pwdata[15:0];
        REG_ACC:    nxt_cur.acc = pwdata[15:0];
        REG_EXT:    nxt_cur.ext = pwdata[15:0];
        REG_IDX:    nxt_cur.idx = pwdata[15:0];
        REG_FLAGS:  nxt_cur.flags = pwdata[1:0];
        REG_STATUS: nxt_cur.status = cur_ff.status & ~pwdata[ST_W-1:0];
        REG_MASK:   nxt_cur.mask = pwdata[ST_W-1:0];
        REG_RFSEL:  nxt_cur.rfSel = pwdata[2:0];
        REG_RFDATA: nxt_cur.rf[cur_ff.rfSel] = pwdata[15:0];
        default:    nxt_cur.pslverr = 1'b1;
      endcase
    end

    // Events set after the clear, so a same-cycle event is never lost
    nxt_cur.status = nxt_cur.status | evt;
    nxt_cur.irq = |(nxt_cur.status & nxt_cur.mask);
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '{state: S_IDLE, mask: RST_MASK, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from flip-flops
  assign prdata   = cur_ff.prdata;
  assign pready   = cur_ff.pready;
  assign pslverr  = cur_ff.pslverr;
  assign memReq   = cur_ff.memReq;
  assign memWrite = cur_ff.memWrite;
  assign memByte  = cur_ff.memByte;
  assign memAddr  = cur_ff.memAddr;
  assign memWdata = cur_ff.memWdata;
  assign irq      = cur_ff.irq;

endmodule

// >>> dv/lsx_mem_model.sv
// Core memory partner: byte array, big-endian words, adjustable acknowledge delay
`timescale 1ns/1ps
module lsx_mem_model (
  // Clock and pacing
  input  wire logic        core_clk,
  input  wire logic [3:0]  ackDelay,
  // Memory port
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic        memByte,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic      [15:0] memRdata,
  output logic             memAck
);
  logic [7:0] memBytes [0:255];
  logic [3:0] waitCnt;
  logic [7:0] a;
  initial begin
    memAck = 1'b0;
    waitCnt = 4'h0;
    memRdata = 16'ha5a5;
  end
  assign a = memAddr[7:0];
  // Answer after ackDelay cycles; data lines toggle whenever nothing is returned
  always @(posedge core_clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq && !memAck) begin
      if (waitCnt < ackDelay) begin
        waitCnt <= waitCnt + 4'h1;
      end else begin
        waitCnt <= 4'h0;
        memAck <= 1'b1;
        if (memWrite && memByte) memBytes[a] <= memWdata[7:0];
        else if (memWrite) {memBytes[a], memBytes[a | 8'h1]} <= memWdata;
        else if (memByte) memRdata <= {~memBytes[a], memBytes[a]}; // Upper byte is junk
        else memRdata <= {memBytes[a], memBytes[a | 8'h1]};
      end
    end
  end
endmodule

// >>> dv/lsx_load_store_unit_properties.sv
// Port timing checker for the load/store unit
`timescale 1ns/1ps
module lsx_load_store_unit_properties (
  // Clock and reset
  input wire logic        core_clk, rst_b,
  // APB
  input wire logic        psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  // Memory and interrupt
  input wire logic        memReq, memWrite, memByte, memAck, irq,
  input wire logic [15:0] memAddr, memWdata, memRdata
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // APB: one wait state, one-cycle answer, error reads zero
  property p_apbWait; psel && penable && !pready |=> pready; endproperty
  a_apbWait: assert property (p_apbWait) else $error("pready late");
  property p_apbPulse; pready |=> !pready; endproperty
  a_apbPulse: assert property (p_apbPulse) else $error("pready held");
  property p_apbCause; pready |-> $past(psel && penable); endproperty
  a_apbCause: assert property (p_apbCause) else $error("pready without access");
  property p_errData; pslverr |-> pready && prdata == 32'h0; endproperty
  a_errData: assert property (p_errData) else $error("bad error answer");
  // Memory request held until acknowledged, then dropped
  property p_memHold;
    memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWdata) && $stable(memWrite);
  endproperty
  a_memHold: assert property (p_memHold) else $error("memory request changed");
  property p_memDrop; memReq && memAck |=> !memReq ##1 !memReq; endproperty
  a_memDrop: assert property (p_memDrop) else $error("memory request kept");
  property p_wordEven; memReq && !memByte |-> !memAddr[0]; endproperty
  a_wordEven: assert property (p_wordEven) else $error("odd word address");
  // Interrupt falls only after a bus write
  property p_irqSticky; irq && !(psel && pwrite) && !$past(psel && pwrite) |=> irq; endproperty
  a_irqSticky: assert property (p_irqSticky) else $error("irq dropped");
  c_store: cover property (memReq && memAck && memWrite);
  c_byte: cover property (memReq && memAck && memByte);
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
endmodule
bind lsx_load_store_unit lsx_load_store_unit_properties lsx_load_store_unit_properties_inst (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .memReq(memReq), .memWrite(memWrite), .memByte(memByte), .memAck(memAck), .irq(irq),
  .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));

// >>> dv/lsx_load_store_unit_bench.sv
// Self-checking bench of the load/store unit
`timescale 1ns/1ps
module lsx_load_store_unit_bench;
  import lsx_pkg::*;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        memReq, memWrite, memByte, memAck, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] memAddr, memWdata, memRdata;
  logic [3:0]  ackDelay;
  int          fail_count, tests_run;
  lsx_load_store_unit lsx_load_store_unit_inst (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .memReq(memReq), .memWrite(memWrite), .memByte(memByte),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .irq(irq));
  lsx_mem_model lsx_mem_model_inst (.core_clk(core_clk), .ackDelay(ackDelay), .memReq(memReq),
    .memWrite(memWrite), .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck));
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, request held until pready is sampled
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // No local limit: a hang is left to the watchdog
    do @(posedge core_clk); while (pready !== 1'b1);
    chk("pready", 32'h1, {31'h0, pready});
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never drives psel twice in one step
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
  endtask
  function automatic logic [31:0] memWord(input logic [7:0] a);
    return {16'h0, lsx_mem_model_inst.memBytes[a], lsx_mem_model_inst.memBytes[a + 8'h1]};
  endfunction
  // Issue one instruction and poll status until it finishes
  task automatic runOp(input logic [4:0] op, input logic [15:0] y, input logic m, output logic [31:0] st);
    wr(REG_STATUS, 32'h7);
    wr(REG_INSTR, {16'h0, 3'h5, op, 8'h3c});
    wr(REG_ADDR, {16'h0, y});
    wr(REG_CTRL, {30'h0, m, 1'b1});
    do rd(REG_STATUS, st); while (st[ST_DONE] !== 1'b1 && st[ST_MVIO] !== 1'b1);
  endtask
  logic [15:0] vals [3] = '{16'h1234, 16'h8001, 16'h0000};
  logic [4:0]  lds [3] = '{OP_LOAD_ACC, OP_LOAD_EXT, OP_LOAD_IDX};
  logic [4:0]  sts [3] = '{OP_STORE_ACC, OP_STORE_EXT, OP_STORE_IDX};
  logic [7:0]  regs [3] = '{REG_ACC, REG_EXT, REG_IDX};
  logic [1:0]  fls [3] = '{FL_POS, FL_NEG, FL_ZERO};
  task automatic testWordLoads;
    logic [31:0] r;
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        lsx_mem_model_inst.memBytes[8'h20] = vals[i][15:8];
        lsx_mem_model_inst.memBytes[8'h21] = vals[i][7:0];
        runOp(lds[j], 16'h0021, 1'b1, r);
        rd(regs[j], r);
        chk("loaded word", {16'h0, vals[i]}, r);
        rd(REG_FLAGS, r);
        chk("load flags", {30'h0, fls[i]}, r);
      end
    end
  endtask
  // Stores with a slow memory: target word written, registers and flags kept
  task automatic testStores;
    logic [31:0] r, fl;
    ackDelay <= 4'h3;
    wr(REG_ACC, 32'ha1b2);
    wr(REG_EXT, 32'hc3d4);
    wr(REG_IDX, 32'he5f6);
    rd(REG_FLAGS, fl);
    for (int j = 0; j < 3; j++) begin
      runOp(sts[j], 16'h0041 + 16'(4 * j), 1'b0, r);
      chk("stored word", j == 0 ? 32'ha1b2 : j == 1 ? 32'hc3d4 : 32'he5f6,
          memWord(8'h40 + 8'(4 * j)));
      for (int k = 0; k < 3; k++) begin
        rd(regs[k], r);
        chk("register kept", k == 0 ? 32'ha1b2 : k == 1 ? 32'hc3d4 : 32'he5f6, r);
      end
      rd(REG_FLAGS, r);
      chk("flags kept", fl, r);
    end
    ackDelay <= 4'h0;
  endtask
  task automatic testBytes;
    logic [31:0] r;
    wr(REG_ACC, 32'h12ab);
    wr(REG_IDX, 32'hffff);
    lsx_mem_model_inst.memBytes[8'h30] = 8'h00;
    lsx_mem_model_inst.memBytes[8'h31] = 8'h77;
    runOp(OP_STORE_RBYTE, 16'h0031, 1'b1, r);
    chk("byte pair", 32'h00ab, memWord(8'h30));
    rd(REG_ACC, r);
    chk("acc kept", 32'h12ab, r);
    runOp(OP_BYTE_IDX, 16'h0031, 1'b1, r);
    rd(REG_IDX, r);
    chk("byte index", 32'h00ab, r);
    rd(REG_FLAGS, r);
    chk("byte flags", {30'h0, FL_POS}, r);
    runOp(OP_BYTE_IDX, 16'h0030, 1'b1, r);
    rd(REG_FLAGS, r);
    chk("zero byte flags", {30'h0, FL_ZERO}, r);
    chk("masked irq", 32'h0, {31'h0, irq});
  endtask
  task automatic testRegFile;
    logic [31:0] r;
    wr(REG_RFSEL, 32'h4);
    wr(REG_RFDATA, 32'h1111);
    wr(REG_RFSEL, 32'h6);
    wr(REG_RFDATA, 32'h0);
    wr(REG_MASK, 32'h2);
    wr(REG_ACC, 32'h8765);
    runOp(OP_STORE_RF, 16'h0003, 1'b1, r);
    wr(REG_RFSEL, 32'h3);
    rd(REG_RFDATA, r);
    chk("regfile write", 32'h8765, r);
    runOp(OP_LOAD_RF, 16'h0006, 1'b1, r);
    rd(REG_ACC, r);
    chk("regfile load", 32'h0, r);
    rd(REG_FLAGS, r);
    chk("regfile flags", {30'h0, FL_ZERO}, r);
    runOp(OP_STORE_RF, 16'h0004, 1'b0, r);
    chk("mode violation", 32'h1, {31'h0, r[ST_MVIO]});
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(REG_RFSEL, 32'h4);
    rd(REG_RFDATA, r);
    chk("regfile guarded", 32'h1111, r);
    wr(REG_STATUS, 32'h7);
    @(posedge core_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(REG_MASK, 32'h0);
  endtask
  task automatic testAddr;
    logic [31:0] r, fl;
    logic e;
    wr(REG_GBASE, 32'h0100);
    wr(REG_PADDR, 32'h0200);
    rd(REG_FLAGS, fl);
    runOp(OP_EFF_ADDR, 16'h0345, 1'b1, r);
    rd(REG_ACC, r);
    chk("effective address", 32'h0245, r);
    rd(REG_FLAGS, r);
    chk("flags kept", fl, r);
    runOp(OP_SAVE_RET, 16'h0051, 1'b1, r);
    chk("return master", 32'h0304, memWord(8'h50));
    runOp(OP_SAVE_RET, 16'h0055, 1'b0, r);
    chk("return slave", 32'h0204, memWord(8'h54));
    apb(8'hfc, 1'b0, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    // Undecoded operation code must flag an unknown op
    runOp(5'h1f, 16'h0000, 1'b1, r);
    chk("unknown op", 32'h1, {31'h0, r[ST_ILL]});
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    {psel, penable, pwrite, rst_b} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    ackDelay = 4'h0;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    testWordLoads();
    testStores();
    testBytes();
    testRegFile();
    testAddr();
    test_done();
  end
  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    test_done();
  end
endmodule
